// ---- logic/cfg_header_upper.sv ----
// Upper configuration header registers 24h..3Ch behind an AHB-Lite slave
//
// Operation
// - Each upper base bit is writable only where the matching setup bit is one.
// - Setup bit 31 at zero disables the upper base register.
// - Upper base holds address bits 63:32 and resets to zero.
// - Setup register loadable from serial memory, SMBus or local processor.
// - Subsystem vendor id in 15:0, subsystem id in 31:16, read-only.
// - Capability pointer reads 80h in low byte, upper bits zero.
// - No expansion ROM; its base register reads zero always.
// - Interrupt line byte is writable by software, stored, resets zero.
// - Interrupt pin reads 01h in reverse mode, 00h in forward mode.
// - Minimum grant is read-only, reverse-mode only, resets zero.
// - Maximum latency is read-only, reverse-mode only, resets zero.
//
// Design decision made here: register access over AHB-Lite.
module cfg_header_upper import cfg_upper_pkg::*; #(
	parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h5A5A, // Arbitrary value
	parameter logic [15:0] SUBSYS_ID = 16'hA5A5, // Arbitrary value
	parameter logic [7:0] MIN_GRANT_VALUE = 8'h00,
	parameter logic [7:0] MAX_LATENCY_VALUE = 8'h00
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic reverse_mode_i,
	input wire logic setup_load_i,
	input wire logic [31:0] setup_load_data_i,
	output logic [31:0] mem3_window_base_high_o,
	output logic window_high_enable_o,
	output logic [7:0] irq_routing_line_o
);

	////////////////////////////////////////////////////////////////////////
	// Strap synchroniser and address phase capture

	logic reverse_meta_q;
	logic reverse_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] base_high_q;
	logic [31:0] base_high_d;
	logic [31:0] setup_q;
	logic [31:0] setup_d;
	logic [7:0] irq_line_q;
	logic [7:0] irq_line_d;
	logic [31:0] rdata_q;

	// Mode strap comes from a pin, so it is synchronised before use
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reverse_meta_q <= 1'b0;
			reverse_q <= 1'b0;
		end else begin
			reverse_meta_q <= reverse_mode_i;
			reverse_q <= reverse_meta_q;
		end
	end

	wire logic trans_valid = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
	wire logic rd_take = trans_valid && !hwrite_i;
	wire logic wr_take = trans_valid && hwrite_i && hsize_i == HSIZE_WORD;
	wire logic [7:0] rd_addr = {haddr_i[7:2], 2'b00};

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= wr_take;
			wr_addr_q <= {haddr_i[7:2], 2'b00};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes (data phase)

	wire logic wr_base = wr_pend_q && wr_addr_q == OFS_MEM3_WINDOW_BASE_HIGH;
	wire logic wr_setup = wr_pend_q && wr_addr_q == OFS_UPPER_SETUP;
	wire logic wr_irq = wr_pend_q && wr_addr_q == OFS_IRQ_CONFIG;
	wire logic window_en = setup_q[SETUP_ENABLE_BIT];

	// Per-bit write mask: only setup-enabled bits take bus data
	always_comb begin
		base_high_d = base_high_q;
		if (wr_base && window_en) begin
			base_high_d = (hwdata_i & setup_q) | (base_high_q & ~setup_q);
		end
	end

	// Local loader wins over a bus write in the same cycle; both are setup sources
	always_comb begin
		setup_d = setup_q;
		if (setup_load_i) begin
			setup_d = setup_load_data_i;
		end else if (wr_setup) begin
			setup_d = hwdata_i;
		end
	end

	always_comb begin
		irq_line_d = irq_line_q;
		if (wr_irq) begin
			irq_line_d = hwdata_i[IRQ_LINE_LSB +: 8];
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			base_high_q <= RST_MEM3_WINDOW_BASE_HIGH;
			setup_q <= RST_UPPER_SETUP;
			irq_line_q <= RST_IRQ_LINE;
		end else begin
			base_high_q <= base_high_d;
			setup_q <= setup_d;
			irq_line_q <= irq_line_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	wire logic [7:0] irq_pin = reverse_q ? IRQ_PIN_REVERSE : IRQ_PIN_FORWARD;
	wire logic [7:0] min_grant = reverse_q ? MIN_GRANT_VALUE : RST_MIN_GRANT;
	wire logic [7:0] max_latency = reverse_q ? MAX_LATENCY_VALUE : RST_MAX_LATENCY;
	wire logic [31:0] irq_word = {max_latency, min_grant, irq_pin, irq_line_d};
	wire logic [31:0] subsys_word = {SUBSYS_ID, SUBSYS_VENDOR_ID};
	wire logic [31:0] cap_word = {24'h000000, CAP_POINTER_VALUE};
	// Disabled window reads back zero so software sees it off
	wire logic [31:0] base_word = window_en ? base_high_d : 32'h0000_0000;

	logic [31:0] rd_mux;
	always_comb begin
		unique case (rd_addr)
			OFS_MEM3_WINDOW_BASE_HIGH: rd_mux = base_word;
			OFS_SUBSYSTEM_IDENTIFIERS: rd_mux = subsys_word;
			OFS_CAPABILITY_LIST_POINTER: rd_mux = cap_word;
			OFS_ROM_WINDOW_BASE: rd_mux = ROM_BASE_VALUE;
			OFS_IRQ_CONFIG: rd_mux = irq_word;
			OFS_UPPER_SETUP: rd_mux = setup_d;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			rdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all registered; zero wait states, response always OKAY

	logic hreadyout_q;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hreadyout_q <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
		end
	end

	assign hrdata_o = rdata_q;
	assign hreadyout_o = hreadyout_q;
	assign hresp_o = 1'b0 & hreadyout_q;
	assign mem3_window_base_high_o = base_high_q;
	assign window_high_enable_o = setup_q[SETUP_ENABLE_BIT];
	assign irq_routing_line_o = irq_line_q;

endmodule : cfg_header_upper

// ---- logic/cfg_upper_pkg.sv ----
// Constants for the upper configuration header register bank
package cfg_upper_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_MEM3_WINDOW_BASE_HIGH = 8'h24;
	localparam logic [7:0] OFS_RESERVED_A = 8'h28;
	localparam logic [7:0] OFS_SUBSYSTEM_IDENTIFIERS = 8'h2C;
	localparam logic [7:0] OFS_RESERVED_B = 8'h30;
	localparam logic [7:0] OFS_CAPABILITY_LIST_POINTER = 8'h34;
	localparam logic [7:0] OFS_ROM_WINDOW_BASE = 8'h38;
	localparam logic [7:0] OFS_IRQ_CONFIG = 8'h3C;
	localparam logic [7:0] OFS_UPPER_SETUP = 8'h40;
	localparam logic [31:0] RST_MEM3_WINDOW_BASE_HIGH = 32'h0000_0000;
	localparam logic [31:0] RST_UPPER_SETUP = 32'h0000_0000;
	localparam logic [7:0] CAP_POINTER_VALUE = 8'h80;
	localparam logic [31:0] ROM_BASE_VALUE = 32'h0000_0000;
	localparam logic [7:0] RST_IRQ_LINE = 8'h00;
	localparam logic [7:0] IRQ_PIN_FORWARD = 8'h00;
	localparam logic [7:0] IRQ_PIN_REVERSE = 8'h01;
	localparam logic [7:0] RST_MIN_GRANT = 8'h00;
	localparam logic [7:0] RST_MAX_LATENCY = 8'h00;
	localparam int unsigned SETUP_ENABLE_BIT = 31;
	localparam int unsigned IRQ_LINE_LSB = 0;
	localparam int unsigned IRQ_PIN_LSB = 8;
	localparam int unsigned MIN_GRANT_LSB = 16;
	localparam int unsigned MAX_LATENCY_LSB = 24;
	localparam int unsigned SUBSYS_VENDOR_LSB = 0;
	localparam int unsigned SUBSYS_ID_LSB = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : cfg_upper_pkg

// ---- tb/cfg_host_model.sv ----
// Configuration host model: one AHB-Lite master doing single word transfers
module cfg_host_model (
	input wire logic ref_clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o = 1'b0,
	output logic [31:0] haddr_o = 32'h0,
	output logic [1:0] htrans_o = 2'h0,
	output logic hwrite_o = 1'b0,
	output logic [2:0] hsize_o = 3'h2,
	output logic [31:0] hwdata_o = 32'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Waits are unbounded here; only the bench watchdog may end a hung transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel_o <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o <= {24'h0, a};
		hwrite_o <= w;
		do @(posedge ref_clk_i); while (!hready_i);
		htrans_o <= 2'h0;
		hwdata_o <= d;
		do @(posedge ref_clk_i); while (!hready_i);
		r = hrdata_i;
	endtask : xfer
endmodule : cfg_host_model

// ---- tb/cfg_header_upper_chk.sv ----
// Assertion checker for the upper header register bank
module cfg_header_upper_chk (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hresp_o,
	input wire logic reverse_mode_i,
	input wire logic setup_load_i,
	input wire logic [31:0] setup_load_data_i,
	input wire logic [31:0] mem3_window_base_high_o,
	input wire logic window_high_enable_o,
	input wire logic [7:0] irq_routing_line_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	wire tk = hsel_i & hready_i & htrans_i[1];
	wire rd = tk & !hwrite_i;
	wire wr = tk & hwrite_i;
	wire [7:0] a = haddr_i[7:0];
	AST_RESP: assert property (hresp_o == 1'b0) else $error("response not okay");
	AST_CAP: assert property (rd && a == 8'h34 |=> hrdata_o == 32'h80) else $error("cap pointer");
	AST_ZERO: assert property (rd && (a == 8'h28 || a == 8'h30 || a == 8'h38) |=> hrdata_o == 32'h0)
		else $error("zero word");
	AST_FWD: assert property (!reverse_mode_i [*3] ##0 (rd && a == 8'h3C) |=> hrdata_o[31:8] == 24'h0)
		else $error("forward irq byte");
	AST_REV: assert property (reverse_mode_i [*3] ##0 (rd && a == 8'h3C) |=> hrdata_o[15:8] == 8'h01)
		else $error("reverse irq pin");
	AST_LINE: assert property (wr && a == 8'h3C |=> ##1 irq_routing_line_o == $past(hwdata_i[7:0]))
		else $error("irq line");
	AST_ENA: assert property (setup_load_i |=> window_high_enable_o == $past(setup_load_data_i[31]))
		else $error("enable");
	AST_BASE: assert property (wr && a == 8'h24 && !window_high_enable_o |-> ##2 $stable(mem3_window_base_high_o))
		else $error("base changed");
	AST_BASE_RST: assert property ($rose(resetn_i) |-> mem3_window_base_high_o == 32'h0) else $error("base reset");
endmodule : cfg_header_upper_chk
bind cfg_header_upper cfg_header_upper_chk chk (.*);

// ---- tb/cfg_header_upper_test.sv ----
// Self-checking testbench for the upper header register bank
module cfg_header_upper_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0, resetn_i = 1'b0, rev = 1'b0, ld = 1'b0;
	logic [31:0] ld_d = 32'h0, rdata, base_high;
	logic hsel, hwrite, rdy, resp, ena;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata;
	logic [7:0] line;
	int err_count = 0, checked = 0;
	initial forever #25 ref_clk_i = ~ref_clk_i;
	cfg_host_model host (.ref_clk_i(ref_clk_i), .hready_i(rdy), .hrdata_i(rdata), .hsel_o(hsel), .haddr_o(haddr),
		.htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
	cfg_header_upper #(.MIN_GRANT_VALUE(8'h12), .MAX_LATENCY_VALUE(8'h34)) DUT (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(resp),
		.reverse_mode_i(rev), .setup_load_i(ld), .setup_load_data_i(ld_d),
		.mem3_window_base_high_o(base_high), .window_high_enable_o(ena), .irq_routing_line_o(line));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(w, a, d, r);
		if (!w) cmp(r, d);
	endtask : rw
	// Read-only and reserved words ignore writes of all ones
	task automatic t_fixed;
		logic [7:0] ofs[6] = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h44};
		logic [31:0] val[6] = '{32'h0, 32'hA5A55A5A, 32'h0, 32'h80, 32'h0, 32'h0};
		rw(0, 8'h24, 32'h0);
		foreach (ofs[i]) begin
			rw(1, ofs[i], 32'hFFFFFFFF);
			rw(0, ofs[i], val[i]);
		end
	endtask : t_fixed
	task automatic t_base;
		rw(1, 8'h24, 32'hFFFFFFFF);
		rw(0, 8'h24, 32'h0);
		cmp(base_high, 32'h0);
		cmp({31'h0, ena}, 32'h0);
		@(posedge ref_clk_i);
		ld <= 1'b1;
		ld_d <= 32'h8000FF00;
		@(posedge ref_clk_i);
		ld <= 1'b0;
		rw(1, 8'h24, 32'hFFFFFFFF);
		rw(0, 8'h24, 32'h8000FF00);
		cmp(base_high, 32'h8000FF00);
		cmp({31'h0, ena}, 32'h1);
		rw(1, 8'h40, 32'h8000000F);
		rw(0, 8'h40, 32'h8000000F);
		rw(1, 8'h24, 32'h0);
		rw(0, 8'h24, 32'h0000FF00);
		cmp(base_high, 32'h0000FF00);
		cmp({31'h0, resp}, 32'h0);
	endtask : t_base
	task automatic t_irq;
		rw(1, 8'h3C, 32'hFFFFFF5A);
		rw(0, 8'h3C, 32'h0000005A);
		cmp({24'h0, line}, 32'h0000005A);
		rev <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rw(0, 8'h3C, 32'h3412015A);
	endtask : t_irq
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		t_fixed();
		t_base();
		t_irq();
		tally_and_finish();
	end
endmodule : cfg_header_upper_test
